// [alc_map.svh]
// Register offsets, field positions, reset values and timing figures
// for the ambient light comparator; included by alc_level_cmp and alc_top.
`ifndef ALC_MAP_SVH
`define ALC_MAP_SVH

// Register offsets
`define ALC_OFF_CFG          8'h0C
`define ALC_OFF_OFFICE_TRIP  8'h0D
`define ALC_OFF_OFFICE_HYS   8'h0E
`define ALC_OFF_DARK_TRIP    8'h0F
`define ALC_OFF_DARK_HYS     8'h10
`define ALC_OFF_IRQ_STATUS   8'h20
`define ALC_OFF_IRQ_MASK     8'h21

// Configuration field positions
`define ALC_CFG_SENSOR_FILTER_TIME_HI      7
`define ALC_CFG_SENSOR_FILTER_TIME_LO      5
`define ALC_CFG_FORCE_BIT    4
`define ALC_CFG_DARK_FLAG    3
`define ALC_CFG_OFFICE_FLAG  2
`define ALC_CFG_DARK_EN      1
`define ALC_CFG_OFFICE_EN    0

// Interrupt status bit positions
`define ALC_IRQ_OFFICE_BIT   0
`define ALC_IRQ_DARK_BIT     1
`define ALC_IRQ_FORCE_BIT    2

// Reset values
`define ALC_RST_BYTE         8'h00
`define ALC_RST_IRQ          3'h0
`define ALC_READ_ZERO        8'h00

// Timing: shortest filter period and clock rate
`define ALC_SENSOR_FILTER_TIME_BASE_US     80000
`define ALC_CLK_MHZ          100
`define ALC_BASE_CYCLES      (`ALC_SENSOR_FILTER_TIME_BASE_US * `ALC_CLK_MHZ)

`endif

// [alc_pkg.sv]
// Types shared by the ambient light comparator modules.
// Assumes alc_map.svh is reachable on the include path.
package alc_pkg;

    // Configuration register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [2:0] sensor_filter_time;
        logic       force_conversion;
        logic       dark_level_flag;
        logic       office_level_flag;
        logic       dark_comparator_enable;
        logic       office_comparator_enable;
    } alc_cfg_t;

    // One comparator's threshold pair
    typedef struct packed {
        logic [7:0] trip_value;
        logic [7:0] hysteresis_value;
    } alc_thr_t;

    // Single conversion sequence; one bit changes per step except DONE to IDLE
    typedef enum logic [1:0] {
        ALC_IDLE = 2'b00,
        ALC_WAIT = 2'b01,
        ALC_DONE = 2'b11
    } alc_conv_state_t;

endpackage

// [alc_level_cmp.sv]
// One level comparator with hysteresis and persistence filter.
// Assumes a one-cycle base tick every shortest filter period.
`timescale 1ns/100ps
`include "alc_map.svh"

module alc_level_cmp
    import alc_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Control
    input  wire logic       cmp_enable,
    input  wire logic [2:0] sensor_filter_time_code,
    input  wire logic       base_tick,
    input  wire logic       force_now,
    input  wire alc_thr_t   thr,
    // Measurement
    input  wire logic       sample_valid,
    input  wire logic [7:0] meas,
    // Result
    output logic            level_flag,
    output logic            flag_change
);

    logic [8:0] release_level;
    logic       below_trip;
    logic       above_release;
    logic       cond_reg;
    logic [7:0] persist_reg;
    logic [7:0] persist_target;
    logic       flag_next;

    // Trip and release thresholds, release one bit wider
    assign release_level  = {1'b0, thr.trip_value} + {1'b0, thr.hysteresis_value};
    assign below_trip     = meas < thr.trip_value;
    assign above_release  = {1'b0, meas} > release_level;
    assign persist_target = 8'h01 << sensor_filter_time_code;

    // Condition that would flip the flag, from latest sample
    always_ff @(posedge ref_clk)
    begin
        if (rst || !cmp_enable)
            cond_reg <= 1'b0;
        else if (sample_valid)
            cond_reg <= level_flag ? above_release : below_trip;
    end

    // Persistence count in base ticks
    always_ff @(posedge ref_clk)
    begin
        if (rst || !cond_reg || force_now || persist_reg == persist_target)
            persist_reg <= 8'h00;
        else if (base_tick)
            persist_reg <= persist_reg + 8'h01;
    end

    // Flag next value: forced sample, or persisted condition
    always_comb
    begin
        flag_next = level_flag;
        if (!cmp_enable)
            flag_next = 1'b0;
        else if (force_now && sample_valid)
            flag_next = level_flag ? !above_release : below_trip;
        else if (cond_reg && persist_reg == persist_target)
            flag_next = !level_flag;
    end

    // Flag register and change pulse
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            level_flag  <= 1'b0;
            flag_change <= 1'b0;
        end
        else
        begin
            level_flag  <= flag_next;
            flag_change <= flag_next != level_flag;
        end
    end

endmodule

// [alc_top.sv]
// Ambient light comparator: registers, filter timebase, single
// conversion sequence, two level comparators and interrupt.
// Assumes the front end presents both measurements with a one-cycle
// valid pulse per conversion, synchronous to ref_clk, and that the
// register master never raises both strobes at once.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "alc_map.svh"

module alc_top
    import alc_pkg::*;
#(
    parameter int BASE_CYCLES = `ALC_BASE_CYCLES
)
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Sensor front end
    input  wire logic       sample_valid,
    input  wire logic [7:0] office_meas,
    input  wire logic [7:0] dark_meas,
    // Results
    output logic            office_level_flag,
    output logic            dark_level_flag,
    output logic            irq
);

    // Base counter wide enough for one shortest filter period
    localparam int BASE_W = $clog2(BASE_CYCLES + 1);
    // Interrupt sources: office change, dark change, forced done
    localparam int IRQ_W  = 3;

    // Register state
    alc_cfg_t          cfg_reg;
    alc_thr_t          office_thr_reg;
    alc_thr_t          dark_thr_reg;

    // Interrupt state
    logic [IRQ_W-1:0]  irq_status_reg;
    logic [IRQ_W-1:0]  irq_mask_reg;
    logic [IRQ_W-1:0]  irq_event;

    // Filter timebase
    logic [BASE_W-1:0] base_cnt_reg;
    logic              base_tick;

    // Single conversion sequence
    alc_conv_state_t   conv_state_reg;
    alc_conv_state_t   conv_state_next;
    logic              force_now;
    logic              force_done;

    // Comparator change pulses
    logic              office_change;
    logic              dark_change;

    // Read multiplexer output
    logic [7:0]        rd_mux;

    // Write decode; unmapped offsets match nothing, so writes there
    // are dropped without side effects
    logic wr_cfg;
    logic wr_office_trip;
    logic wr_office_hys;
    logic wr_dark_trip;
    logic wr_dark_hys;
    logic wr_irq_status;
    logic wr_irq_mask;

    assign wr_cfg         = reg_wr && reg_addr == `ALC_OFF_CFG;
    assign wr_office_trip = reg_wr && reg_addr == `ALC_OFF_OFFICE_TRIP;
    assign wr_office_hys  = reg_wr && reg_addr == `ALC_OFF_OFFICE_HYS;
    assign wr_dark_trip   = reg_wr && reg_addr == `ALC_OFF_DARK_TRIP;
    assign wr_dark_hys    = reg_wr && reg_addr == `ALC_OFF_DARK_HYS;
    assign wr_irq_status  = reg_wr && reg_addr == `ALC_OFF_IRQ_STATUS;
    assign wr_irq_mask    = reg_wr && reg_addr == `ALC_OFF_IRQ_MASK;

    // Base tick every shortest filter period. Every filter code is a
    // power-of-two multiple of this period, so the comparators only
    // count ticks. The tick runs free, so the first counted tick of a
    // new condition may come early by up to one base period.
    always_ff @(posedge ref_clk)
    begin
        if (rst || base_tick)
            base_cnt_reg <= '0;
        else
            base_cnt_reg <= base_cnt_reg + 1'b1;
    end

    // Tick on the last count of the period
    assign base_tick = base_cnt_reg == BASE_W'(BASE_CYCLES - 1);

    // Filter time field; a running count is judged against the new code
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            cfg_reg.sensor_filter_time <= 3'h0;
        else if (wr_cfg)
            cfg_reg.sensor_filter_time <= reg_wdata[`ALC_CFG_SENSOR_FILTER_TIME_HI:`ALC_CFG_SENSOR_FILTER_TIME_LO];
    end

    // Dark comparator enable
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            cfg_reg.dark_comparator_enable <= 1'b0;
        else if (wr_cfg)
            cfg_reg.dark_comparator_enable <= reg_wdata[`ALC_CFG_DARK_EN];
    end

    // Office comparator enable
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            cfg_reg.office_comparator_enable <= 1'b0;
        else if (wr_cfg)
            cfg_reg.office_comparator_enable <= reg_wdata[`ALC_CFG_OFFICE_EN];
    end

    // Force bit: written by software, cleared when the conversion ends.
    // A write in the DONE cycle wins, so software can re-arm at once;
    // writing zero while waiting cancels the request.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            cfg_reg.force_conversion <= 1'b0;
        else if (wr_cfg)
            cfg_reg.force_conversion <= reg_wdata[`ALC_CFG_FORCE_BIT]; // write wins
        else if (force_done)
            cfg_reg.force_conversion <= 1'b0;
    end

    // Read-only flags mirror the comparators; writes to these two
    // bits have no storage behind them
    always_comb
    begin
        cfg_reg.dark_level_flag   = dark_level_flag;
        cfg_reg.office_level_flag = office_level_flag;
    end

    // Office threshold pair; the release level is trip plus
    // hysteresis, formed one bit wider inside the comparator
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            office_thr_reg <= {`ALC_RST_BYTE, `ALC_RST_BYTE};
        else
        begin
            if (wr_office_trip)
                office_thr_reg.trip_value <= reg_wdata;
            if (wr_office_hys)
                office_thr_reg.hysteresis_value <= reg_wdata;
        end
    end

    // Dark threshold pair; same layout as the office pair,
    // with a finer current step per code
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            dark_thr_reg <= {`ALC_RST_BYTE, `ALC_RST_BYTE};
        else
        begin
            if (wr_dark_trip)
                dark_thr_reg.trip_value <= reg_wdata;
            if (wr_dark_hys)
                dark_thr_reg.hysteresis_value <= reg_wdata;
        end
    end

    // Single conversion sequence. IDLE waits for the force bit, WAIT
    // holds until the next front end sample, DONE lasts one cycle and
    // clears the force bit. Clearing the force bit in WAIT cancels the
    // request without a done event. The spare code falls back to
    // IDLE.
    always_comb
    begin
        conv_state_next = conv_state_reg;
        unique case (conv_state_reg)
            ALC_IDLE:
            begin
                if (cfg_reg.force_conversion)
                    conv_state_next = ALC_WAIT;
            end
            ALC_WAIT:
            begin
                if (!cfg_reg.force_conversion)
                    conv_state_next = ALC_IDLE;                // cancelled
                else if (sample_valid)
                    conv_state_next = ALC_DONE;
            end
            ALC_DONE:
            begin
                conv_state_next = ALC_IDLE;
            end
            default:
            begin
                conv_state_next = ALC_IDLE;
            end
        endcase
    end

    // Sequence state register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            conv_state_reg <= ALC_IDLE;
        else
            conv_state_reg <= conv_state_next;
    end

    // Forced sample taken in WAIT; bit cleared on the DONE cycle.
    // Both comparators share the same forced sample.
    assign force_now  = conv_state_reg == ALC_WAIT && cfg_reg.force_conversion;
    assign force_done = conv_state_reg == ALC_DONE;

    // Office comparator. Shares filter code, base tick and forced
    // sample with the dark comparator, so both flags are judged on
    // the same forced conversion.
    alc_level_cmp u_office
    (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .cmp_enable   (cfg_reg.office_comparator_enable),
        .sensor_filter_time_code    (cfg_reg.sensor_filter_time),
        .base_tick    (base_tick),
        .force_now    (force_now),
        .thr          (office_thr_reg),
        .sample_valid (sample_valid),
        .meas         (office_meas),
        .level_flag   (office_level_flag),
        .flag_change  (office_change)
    );

    // Dark comparator. Independent enable; when disabled its flag
    // drops on the next edge and its persistence count restarts,
    // which raises a change event if the flag was set.
    alc_level_cmp u_dark
    (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .cmp_enable   (cfg_reg.dark_comparator_enable),
        .sensor_filter_time_code    (cfg_reg.sensor_filter_time),
        .base_tick    (base_tick),
        .force_now    (force_now),
        .thr          (dark_thr_reg),
        .sample_valid (sample_valid),
        .meas         (dark_meas),
        .level_flag   (dark_level_flag),
        .flag_change  (dark_change)
    );

    // Interrupt events, one-cycle pulses; a flag change counts in
    // either direction
    always_comb
    begin
        irq_event                      = 3'h0;
        irq_event[`ALC_IRQ_OFFICE_BIT] = office_change;
        irq_event[`ALC_IRQ_DARK_BIT]   = dark_change;
        irq_event[`ALC_IRQ_FORCE_BIT]  = force_done;
    end

    // Sticky status per source; an event in the same cycle as a
    // write-one-to-clear wins, so no change is ever lost
    generate
        for (genvar b = 0; b < IRQ_W; b++)
        begin : g_status
            always_ff @(posedge ref_clk)
            begin
                if (rst)
                    irq_status_reg[b] <= 1'b0;
                else if (irq_event[b])
                    irq_status_reg[b] <= 1'b1;
                else if (wr_irq_status && reg_wdata[b])
                    irq_status_reg[b] <= 1'b0;
            end
        end
    endgenerate

    // Interrupt mask, same layout as the status register;
    // a masked source still latches its status bit
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            irq_mask_reg <= `ALC_RST_IRQ;
        else if (wr_irq_mask)
            irq_mask_reg <= reg_wdata[2:0];
    end

    // Level interrupt, high while any unmasked status bit is set;
    // unmasking a pending bit raises it at once
    assign irq = |(irq_status_reg & irq_mask_reg);

    // Read multiplexer; unmapped offsets read as zero, and the two
    // flag bits of the configuration byte come live from the comparators
    always_comb
    begin
        rd_mux = `ALC_READ_ZERO;
        unique case (reg_addr)
            `ALC_OFF_CFG:         rd_mux = cfg_reg;
            `ALC_OFF_OFFICE_TRIP: rd_mux = office_thr_reg.trip_value;
            `ALC_OFF_OFFICE_HYS:  rd_mux = office_thr_reg.hysteresis_value;
            `ALC_OFF_DARK_TRIP:   rd_mux = dark_thr_reg.trip_value;
            `ALC_OFF_DARK_HYS:    rd_mux = dark_thr_reg.hysteresis_value;
            `ALC_OFF_IRQ_STATUS:  rd_mux = {5'h00, irq_status_reg};
            `ALC_OFF_IRQ_MASK:    rd_mux = {5'h00, irq_mask_reg};
            default:              rd_mux = `ALC_READ_ZERO;
        endcase
    end

    // Read data stands one cycle after the strobe and is zero otherwise,
    // so a stale value never lingers on the port
    always_ff @(posedge ref_clk)
    begin
        if (rst || !reg_rd)
            reg_rdata <= `ALC_READ_ZERO;
        else
            reg_rdata <= rd_mux;
    end

endmodule

// [alc_top_props.sv]
// Concurrent checks on the ambient light comparator top level.
// Sees only the top ports; shadows thresholds, enables and samples.
`timescale 1ns/100ps

module alc_top_props
#(
    parameter int BASE_CYCLES = 10
)
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Sensor and results
    input wire logic       sample_valid,
    input wire logic [7:0] office_meas,
    input wire logic [7:0] dark_meas,
    input wire logic       office_level_flag,
    input wire logic       dark_level_flag,
    input wire logic       irq
);
    logic [7:0] otrip, ohys, dtrip, dhys, om, dm;
    logic       oen, den, pend;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Shadow settings; a config write beats a same-edge sample
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            {otrip, ohys, dtrip, dhys, om, dm, oen, den, pend} <= '0;
        end
        else
        begin
            if (sample_valid)
            begin
                om   <= office_meas;
                dm   <= dark_meas;
                pend <= 1'b0;
            end
            if (reg_wr && reg_addr == 8'h0C) {pend, den, oen} <= {reg_wdata[4], reg_wdata[1:0]};
            if (reg_wr && reg_addr == 8'h0D) otrip <= reg_wdata;
            if (reg_wr && reg_addr == 8'h0E) ohys <= reg_wdata;
            if (reg_wr && reg_addr == 8'h0F) dtrip <= reg_wdata;
            if (reg_wr && reg_addr == 8'h10) dhys <= reg_wdata;
        end
    end

    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_rd_flags;
        reg_rd && reg_addr == 8'h0C |=>
            reg_rdata[3:2] == {$past(dark_level_flag), $past(office_level_flag)};
    endproperty
    a_rd_flags: assert property (p_rd_flags) else $error("flag bits wrong");
    property p_off_dis;
        !oen |=> !office_level_flag;
    endproperty
    a_off_dis: assert property (p_off_dis) else $error("office flag while off");
    property p_dark_dis;
        !den |=> !dark_level_flag;
    endproperty
    a_dark_dis: assert property (p_dark_dis) else $error("dark flag while off");
    property p_off_set;
        $rose(office_level_flag) |-> om < otrip || $past(om) < otrip;
    endproperty
    a_off_set: assert property (p_off_set) else $error("office set above trip");
    property p_off_clr;
        $fell(office_level_flag) && oen |->
            9'(om) > 9'(otrip) + 9'(ohys) || 9'($past(om)) > 9'(otrip) + 9'(ohys);
    endproperty
    a_off_clr: assert property (p_off_clr) else $error("office cleared early");
    property p_dark_set;
        $rose(dark_level_flag) |-> dm < dtrip || $past(dm) < dtrip;
    endproperty
    a_dark_set: assert property (p_dark_set) else $error("dark set above trip");
    property p_dark_clr;
        $fell(dark_level_flag) && den |->
            9'(dm) > 9'(dtrip) + 9'(dhys) || 9'($past(dm)) > 9'(dtrip) + 9'(dhys);
    endproperty
    a_dark_clr: assert property (p_dark_clr) else $error("dark cleared early");
    property p_force_off;
        pend && sample_valid && oen && office_meas < otrip |=> office_level_flag;
    endproperty
    a_force_off: assert property (p_force_off) else $error("forced office miss");
    property p_force_dark;
        pend && sample_valid && den && 9'(dark_meas) > 9'(dtrip) + 9'(dhys) |=> !dark_level_flag;
    endproperty
    a_force_dark: assert property (p_force_dark) else $error("forced dark miss");
endmodule

bind alc_top alc_top_props #(.BASE_CYCLES(BASE_CYCLES)) props_u (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid), .office_meas(office_meas),
    .dark_meas(dark_meas), .office_level_flag(office_level_flag),
    .dark_level_flag(dark_level_flag), .irq(irq));

// [alc_sensor_model.sv]
// Photosensor front end model feeding both measurements.
// Assumes the bench sets light levels and sample spacing.
`timescale 1ns/100ps

module alc_sensor_model
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Bench controls
    input  wire logic [7:0] gap,
    input  wire logic [7:0] office_lvl,
    input  wire logic [7:0] dark_lvl,
    // Measurement
    output logic            sample_valid,
    output logic [7:0]      office_meas,
    output logic [7:0]      dark_meas
);
    logic [7:0] cnt;
    logic       hit;

    assign hit = !rst && cnt >= gap;

    // One pulse every gap+1 cycles; data inverted between pulses
    always_ff @(posedge ref_clk)
    begin
        cnt          <= (rst || hit) ? 8'h00 : cnt + 8'h01;
        sample_valid <= hit;
        office_meas  <= rst ? 8'h00 : (hit ? office_lvl : ~office_meas);
        dark_meas    <= rst ? 8'h00 : (hit ? dark_lvl : ~dark_meas);
    end
endmodule

// [ambient_light_comparator_tb.sv]
// Self-checking bench for the ambient light comparator.
// Assumes alc_top, its checker and the sensor model are compiled.
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end

module ambient_light_comparator_tb;
    localparam int BASE  = 10;
    localparam int WATCH = 20000;
    logic       ref_clk   = 1'b0;
    logic       rst       = 1'b1;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata, office_meas, dark_meas;
    logic       sample_valid, office_level_flag, dark_level_flag, irq;
    logic [7:0] gap        = 8'h04;
    logic [7:0] office_lvl = 8'hFF;
    logic [7:0] dark_lvl   = 8'hFF;
    logic       rd_q       = 1'b0;
    logic [7:0] exp_v;
    logic [7:0] expq [$];
    logic [31:0] seed      = 32'hF7C5;
    logic [7:0] addrs [8]  = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h20, 8'h21, 8'h30};
    int         failures   = 0;
    int         compares   = 0;
    int         n;

    always #5 ref_clk = ~ref_clk;

    alc_top #(.BASE_CYCLES(BASE)) dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .office_meas(office_meas), .dark_meas(dark_meas),
        .office_level_flag(office_level_flag), .dark_level_flag(dark_level_flag), .irq(irq));
    alc_sensor_model model_u (.ref_clk(ref_clk), .rst(rst), .gap(gap), .office_lvl(office_lvl),
        .dark_lvl(dark_lvl), .sample_valid(sample_valid), .office_meas(office_meas),
        .dark_meas(dark_meas));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Bus accesses leave strobes up so accesses may run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        reg_addr <= a;
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
    endtask
    task automatic idle(input int c);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (c) @(posedge ref_clk);
    endtask
    task automatic wait_flag(input logic e, output int c);
        c = 0;
        while (office_level_flag !== e && c < 3000)
        begin
            @(posedge ref_clk);
            c++;
        end
    endtask
    task automatic report_and_stop;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Read data compared with the oldest noted expectation
    always @(posedge ref_clk)
    begin
        rd_q <= reg_rd;
        if (rd_q && expq.size() > 0)
        begin
            exp_v = expq.pop_front();
            `CHK(reg_rdata, exp_v)
        end
    end

    // Cut a hang short after the expected run length
    initial
    begin
        repeat (WATCH) @(posedge ref_clk);
        failures++;
        report_and_stop;
    end

    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            wr(8'h0D + 8'(i), seed[7:0]);
            rd(8'h0D + 8'(i), seed[7:0]);
        end
        wr(8'h0C, 8'h0C);
        wr(8'h30, 8'hFF);
        rd(8'h0C, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h0D, 8'h80);
        wr(8'h0E, 8'h10);
        wr(8'h0F, 8'h40);
        wr(8'h10, 8'h08);
        wr(8'h21, 8'h07);
        // Forced conversion with the longest filter, both levels low
        office_lvl <= 8'h7F;
        dark_lvl   <= 8'h3F;
        wr(8'h0C, 8'hF3);
        idle(12);
        `CHK(irq, 1'b1)
        rd(8'h0C, 8'hEF);
        rd(8'h20, 8'h07);
        wr(8'h20, 8'h07);
        idle(1);
        `CHK(irq, 1'b0)
        // Second forced conversion clears the dark flag
        dark_lvl <= 8'h49;
        wr(8'h0C, 8'hF3);
        idle(12);
        rd(8'h0C, 8'hE7);
        rd(8'h20, 8'h06);
        wr(8'h21, 8'h01);
        idle(1);
        `CHK(irq, 1'b0)
        wr(8'h21, 8'h02);
        idle(1);
        `CHK(irq, 1'b1)
        wr(8'h0C, 8'h00);
        idle(2);
        `CHK(office_level_flag, 1'b0)
        // Continuous mode: flag held at trip plus hysteresis
        wr(8'h0C, 8'h01); // enables only; backlight adjust is software's
        idle(1);
        wait_flag(1'b1, n);
        `CHK(office_level_flag, 1'b1)
        office_lvl <= 8'h90;
        idle(80);
        `CHK(office_level_flag, 1'b1)
        // Persistence time for every filter code
        gap <= 8'h00;
        for (int f = 0; f < 8; f++)
        begin
            wr(8'h0C, {3'(f), 5'h01});
            office_lvl <= f[0] ? 8'h7F : 8'h91;
            idle(1);
            wait_flag(f[0], n);
            `CHK(n >= ((1 << f) - 1) * BASE && n <= (1 << f) * BASE + 6, 1'b1)
        end
        report_and_stop;
    end
endmodule
